//--- logic/dcb_cmd_bank.sv
// Command-data register bank of the drive, written and read by the
// serial field link through a simple function-code port.
// Assumes the link framing decodes each request into one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module dcb_cmd_bank
  import dcb_pkg::*;
#(
  parameter int HOLD_CYC = FAULT_HOLD_CYC
) (
  input  wire logic        clk,              // 250 MHz core clock
  input  wire logic        sys_rst,          // Synchronous reset, high
  input  wire logic        cmd_wr,           // Write strobe, one cycle
  input  wire logic        cmd_rd,           // Read strobe, one cycle
  input  wire logic [7:0]  cmd_code,         // Function code number
  input  wire logic [15:0] cmd_wdata,        // Write word
  input  wire logic        link_src_valid,   // Source selections allow link
  input  wire logic        link_enable_input,// Enable pin, asynchronous
  input  wire logic [1:0]  pid_mode_select,  // PID control mode
  input  wire logic [15:0] freq_limit_pu,    // Upper limit, per-unit
  output logic [15:0]      cmd_rdata,        // Read word
  output logic             cmd_rvalid,       // Read word valid, pulse
  output logic [2:0]       freq_src,         // One-hot chosen source
  output logic [15:0]      freq_pu_applied,  // Clamped per-unit ref
  output logic [15:0]      freq_hz_applied,  // Hz ref, 0.01 Hz steps
  output logic [15:0]      speed_applied,    // Speed ref, rpm
  output logic [15:0]      pid_applied,      // PID setpoint in use
  output logic [15:0]      ext_pid_one,      // External PID one
  output logic [15:0]      ext_pid_two,      // External PID two
  output logic [15:0]      ext_pid_three,    // External PID three
  output logic [15:0]      gp_input_word,    // Run word to terminals
  output logic             fault_reset,      // Internal alarm reset
  output logic             rtc_load,         // Clock load pulse
  output logic [15:0]      rtc_year_month,   // Committed year/month
  output logic [15:0]      rtc_day_hour,     // Committed day/hour
  output logic [15:0]      rtc_min_sec       // Committed minute/second
);

  // Stored command words, as written by the link
  logic [15:0] pu_ff, nxt_pu;         // Per-unit frequency
  logic [15:0] hz_ff, nxt_hz;         // Hz frequency
  logic [15:0] run_ff, nxt_run;       // Run command word
  logic [15:0] pid_ff, nxt_pid;       // PID setpoint
  logic [15:0] spd_ff, nxt_spd;       // Speed setpoint
  logic [15:0] ex1_ff, nxt_ex1;       // External PID one
  logic [15:0] ex2_ff, nxt_ex2;       // External PID two
  logic [15:0] ex3_ff, nxt_ex3;       // External PID three
  logic [15:0] ym_ff, nxt_ym;         // Staged year/month
  logic [15:0] dh_ff, nxt_dh;         // Staged day/hour
  logic [15:0] ms_ff, nxt_ms;         // Staged minute/second
  logic [15:0] cmt_ff, nxt_cmt;       // Commit word

  // Read port
  logic [15:0] rdata_ff, nxt_rdata;   // Read data
  logic        rvalid_ff, nxt_rvalid; // Read valid

  // Applied values
  dcb_src_t    src_ff, nxt_src;       // Chosen source
  logic [15:0] fpu_ff, nxt_fpu;       // Clamped per-unit
  logic [15:0] pida_ff, nxt_pida;     // Applied PID

  // Clock commit outputs
  logic        load_ff, nxt_load;     // Load pulse
  logic [15:0] rym_ff, nxt_rym;       // Committed year/month
  logic [15:0] rdh_ff, nxt_rdh;       // Committed day/hour
  logic [15:0] rms_ff, nxt_rms;       // Committed minute/second

  // Enable pin synchroniser
  logic        le_meta_ff;            // First stage, read by second only
  logic        le_sync_ff;            // Usable enable level

  // Decodes and derived terms
  logic        wr_hit_run;            // Write to run word
  logic        wr_hit_clr;            // Write to fault-clear
  logic        link_ok;               // Link side valid
  logic        word_reset;            // Bit 15 high-to-low on run word
  logic        clr_start;             // Start the reset hold
  logic signed [15:0] lim;            // Effective per-unit limit
  logic signed [15:0] neg_lim;        // Its negative
  logic signed [15:0] pid_lo;         // PID lower bound
  logic signed [15:0] fpu_clamped;    // Clamp result, frequency
  logic signed [15:0] pid_clamped;    // Clamp result, PID

  // Two-flop synchroniser for the enable pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      le_meta_ff <= 1'b0;
      le_sync_ff <= 1'b0;
    end else begin
      le_meta_ff <= link_enable_input;
      le_sync_ff <= le_meta_ff;
    end
  end

  // Request decodes and alarm-reset triggers
  always_comb begin
    wr_hit_run = cmd_wr && (cmd_code == CODE_RUN_WORD);
    wr_hit_clr = cmd_wr && (cmd_code == CODE_FAULT_CLR);
    link_ok    = link_src_valid && le_sync_ff;
    // Set then cleared by the host, only when link side is valid
    word_reset = wr_hit_run && run_ff[FAULT_BIT]
                 && !cmd_wdata[FAULT_BIT] && link_ok;
    // Writing one always acts, whatever the link source
    clr_start  = (wr_hit_clr && (cmd_wdata == COMMIT_GO))
                 || word_reset;
  end

  // Stored words: any 16-bit pattern is accepted as written
  always_comb begin
    nxt_pu  = pu_ff;
    nxt_hz  = hz_ff;
    nxt_run = run_ff;
    nxt_pid = pid_ff;
    nxt_spd = spd_ff;
    nxt_ex1 = ex1_ff;
    nxt_ex2 = ex2_ff;
    nxt_ex3 = ex3_ff;
    nxt_ym  = ym_ff;
    nxt_dh  = dh_ff;
    nxt_ms  = ms_ff;
    // Commit word clears itself once the load has gone out
    nxt_cmt = load_ff ? REG_RST : cmt_ff;
    if (cmd_wr) begin
      case (cmd_code)
        CODE_FREQ_PU:  nxt_pu  = cmd_wdata;
        CODE_FREQ_HZ:  nxt_hz  = cmd_wdata;
        CODE_RUN_WORD: nxt_run = cmd_wdata;
        CODE_PID:      nxt_pid = cmd_wdata;
        CODE_SPEED:    nxt_spd = cmd_wdata;
        CODE_EXT_PID1: nxt_ex1 = cmd_wdata;
        CODE_EXT_PID2: nxt_ex2 = cmd_wdata;
        CODE_EXT_PID3: nxt_ex3 = cmd_wdata;
        CODE_CLK_YM:   nxt_ym  = cmd_wdata;
        CODE_CLK_DH:   nxt_dh  = cmd_wdata;
        CODE_CLK_MS:   nxt_ms  = cmd_wdata;
        CODE_CLK_CMT:  nxt_cmt = cmd_wdata;
        default:       nxt_pu  = pu_ff;              // Unmapped, ignored
      endcase
    end
  end

  // Stored word registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pu_ff  <= REG_RST;
      hz_ff  <= REG_RST;
      run_ff <= REG_RST;
      pid_ff <= REG_RST;
      spd_ff <= REG_RST;
      ex1_ff <= REG_RST;
      ex2_ff <= REG_RST;
      ex3_ff <= REG_RST;
      ym_ff  <= REG_RST;
      dh_ff  <= REG_RST;
      ms_ff  <= REG_RST;
      cmt_ff <= REG_RST;
    end else begin
      pu_ff  <= nxt_pu;
      hz_ff  <= nxt_hz;
      run_ff <= nxt_run;
      pid_ff <= nxt_pid;
      spd_ff <= nxt_spd;
      ex1_ff <= nxt_ex1;
      ex2_ff <= nxt_ex2;
      ex3_ff <= nxt_ex3;
      ym_ff  <= nxt_ym;
      dh_ff  <= nxt_dh;
      ms_ff  <= nxt_ms;
      cmt_ff <= nxt_cmt;
    end
  end

  // Read mux: stored words, never the applied values
  always_comb begin
    nxt_rvalid = cmd_rd;
    nxt_rdata  = rdata_ff;
    if (cmd_rd) begin
      case (cmd_code)
        CODE_FREQ_PU:   nxt_rdata = pu_ff;
        CODE_FREQ_HZ:   nxt_rdata = hz_ff;
        CODE_RUN_WORD:  nxt_rdata = run_ff;
        CODE_PID:       nxt_rdata = pid_ff;
        CODE_FAULT_CLR: nxt_rdata = REG_RST;
        CODE_SPEED:     nxt_rdata = spd_ff;
        CODE_EXT_PID1:  nxt_rdata = ex1_ff;
        CODE_EXT_PID2:  nxt_rdata = ex2_ff;
        CODE_EXT_PID3:  nxt_rdata = ex3_ff;
        CODE_CLK_YM:    nxt_rdata = ym_ff;
        CODE_CLK_DH:    nxt_rdata = dh_ff;
        CODE_CLK_MS:    nxt_rdata = ms_ff;
        CODE_CLK_CMT:   nxt_rdata = cmt_ff;
        default:        nxt_rdata = REG_RST;         // Unmapped reads zero
      endcase
    end
  end

  // Read registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff  <= REG_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Limit: the configured upper limit when 0 up to below full scale, else full scale
  always_comb begin
    lim = FULL_SCALE_PU;
    if (($signed(freq_limit_pu) >= S16_ZERO)
        && ($signed(freq_limit_pu) < FULL_SCALE_PU)) begin
      lim = $signed(freq_limit_pu);
    end
    neg_lim = -lim;
    // Process PID floors the setpoint at zero
    if ((pid_mode_select == PID_MODE_PROC1)
        || (pid_mode_select == PID_MODE_PROC2)) begin
      pid_lo = S16_ZERO;
    end else begin
      pid_lo = S16_MIN;
    end
  end

  // Per-unit frequency bounded to the limit
  dcb_clamp #(.W(WORD_W)) u_freq_clamp (
    .value   ($signed(pu_ff)),
    .lo      (neg_lim),
    .hi      (lim),
    .clamped (fpu_clamped)
  );

  // PID setpoint floored in process mode
  dcb_clamp #(.W(WORD_W)) u_pid_clamp (
    .value   ($signed(pid_ff)),
    .lo      (pid_lo),
    .hi      (S16_MAX),
    .clamped (pid_clamped)
  );

  // Source precedence and clock commit
  always_comb begin
    if (pu_ff != REG_RST) begin
      nxt_src = SRC_PU;
    end else if (hz_ff != REG_RST) begin
      nxt_src = SRC_HZ;
    end else begin
      nxt_src = SRC_SPEED;
    end
    nxt_fpu  = fpu_clamped;
    nxt_pida = pid_clamped;
    nxt_load = (cmt_ff == COMMIT_GO) && !load_ff;
    nxt_rym  = nxt_load ? ym_ff : rym_ff;
    nxt_rdh  = nxt_load ? dh_ff : rdh_ff;
    nxt_rms  = nxt_load ? ms_ff : rms_ff;
  end

  // Applied and commit registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_ff  <= SRC_SPEED;
      fpu_ff  <= REG_RST;
      pida_ff <= REG_RST;
      load_ff <= 1'b0;
      rym_ff  <= REG_RST;
      rdh_ff  <= REG_RST;
      rms_ff  <= REG_RST;
    end else begin
      src_ff  <= nxt_src;
      fpu_ff  <= nxt_fpu;
      pida_ff <= nxt_pida;
      load_ff <= nxt_load;
      rym_ff  <= nxt_rym;
      rdh_ff  <= nxt_rdh;
      rms_ff  <= nxt_rms;
    end
  end

  // Timed internal alarm reset, no clearing write needed
  dcb_hold_timer #(.HOLD(HOLD_CYC)) u_fault_hold (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (clr_start),
    .active  (fault_reset)
  );

  // Outputs, each straight from a register
  assign cmd_rdata       = rdata_ff;
  assign cmd_rvalid      = rvalid_ff;
  assign freq_src        = src_ff;
  assign freq_pu_applied = fpu_ff;
  assign freq_hz_applied = hz_ff;
  assign speed_applied   = spd_ff;
  assign pid_applied     = pida_ff;
  assign ext_pid_one     = ex1_ff;
  assign ext_pid_two     = ex2_ff;
  assign ext_pid_three   = ex3_ff;
  // Run bits pass through untouched, so a held run resumes at reset
  assign gp_input_word   = run_ff;
  assign rtc_load        = load_ff;
  assign rtc_year_month  = rym_ff;
  assign rtc_day_hour    = rdh_ff;
  assign rtc_min_sec     = rms_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  pu_wins_a: assert property (pu_ff != REG_RST |=> src_ff == SRC_PU)
    else $error("per-unit not chosen");
  hz_wins_a: assert property ((pu_ff == REG_RST) && (hz_ff != REG_RST)
    |=> src_ff == SRC_HZ)
    else $error("hz not chosen");
  freq_bound_a: assert property (
    $signed(fpu_ff) <= FULL_SCALE_PU && $signed(fpu_ff) >= -FULL_SCALE_PU)
    else $error("applied per-unit beyond full scale");
  pid_floor_a: assert property (((pid_mode_select == PID_MODE_PROC1)
    || (pid_mode_select == PID_MODE_PROC2)) && $stable(pid_mode_select)
    && $signed(pid_ff) < S16_ZERO |=> pida_ff == REG_RST)
    else $error("negative pid applied");
  read_back_a: assert property (cmd_rd && cmd_code == CODE_FREQ_PU
    |=> cmd_rvalid && cmd_rdata == $past(pu_ff))
    else $error("read not last written");
  clr_reads_a: assert property (cmd_rd && cmd_code == CODE_FAULT_CLR
    |=> cmd_rdata == REG_RST)
    else $error("fault clear read nonzero");
  commit_load_a: assert property (cmd_wr
    && cmd_code == CODE_CLK_CMT && cmd_wdata == COMMIT_GO ##1 !cmd_wr[*2]
    |-> rtc_load ##1 (cmt_ff == REG_RST && rtc_year_month == ym_ff))
    else $error("clock commit failed");
  word_gate_a: assert property (wr_hit_run && !link_ok && !wr_hit_clr
    && !fault_reset |=> !fault_reset)
    else $error("word reset without link");
  clr_always_a: assert property (wr_hit_clr
    && cmd_wdata == COMMIT_GO |=> fault_reset [*3])
    else $error("fault clear ignored");

  pu_used_c: cover property (src_ff == SRC_PU ##1 src_ff == SRC_HZ);
  commit_c: cover property (rtc_load);
  word_rst_c: cover property (word_reset);

endmodule : dcb_cmd_bank
`default_nettype wire

//--- include/dcb_pkg.sv
// Constants of the drive command-data bank: function codes, scaling
// and timing. Assumes a 250 MHz core clock behind the field link.
`default_nettype none
package dcb_pkg;

  // Function codes of the command-data group, as the link addresses them
  localparam logic [7:0] CODE_FREQ_PU   = 8'h01; // freq_ref_per_unit
  localparam logic [7:0] CODE_FREQ_HZ   = 8'h05; // freq_ref_hz
  localparam logic [7:0] CODE_RUN_WORD  = 8'h06; // run_command_word
  localparam logic [7:0] CODE_PID       = 8'h0D; // pid_setpoint (13)
  localparam logic [7:0] CODE_FAULT_CLR = 8'h0E; // fault_clear_pulse (14)
  localparam logic [7:0] CODE_SPEED     = 8'h13; // speed_setpoint (19)
  localparam logic [7:0] CODE_EXT_PID1  = 8'h1F; // ext_pid_setpoint_one (31)
  localparam logic [7:0] CODE_EXT_PID2  = 8'h20; // ext_pid_setpoint_two (32)
  localparam logic [7:0] CODE_EXT_PID3  = 8'h21; // ext_pid_setpoint_three
  localparam logic [7:0] CODE_CLK_YM    = 8'h5A; // clock_year_month (90)
  localparam logic [7:0] CODE_CLK_DH    = 8'h5B; // clock_day_hour (91)
  localparam logic [7:0] CODE_CLK_MS    = 8'h5C; // clock_minute_second (92)
  localparam logic [7:0] CODE_CLK_CMT   = 8'h5D; // clock_commit (93)

  // Word layout and reset values
  localparam int          WORD_W        = 16;       // Register width
  localparam int          FAULT_BIT     = 15;       // Reset bit of run word
  localparam logic [15:0] REG_RST       = 16'h0000; // Reset of all words
  localparam logic [15:0] COMMIT_GO     = 16'h0001; // Commit request value

  // Scaling: full scale of per-unit quantities and signed word bounds
  localparam logic signed [15:0] FULL_SCALE_PU = 16'sh4E20; // 20000
  localparam logic signed [15:0] S16_MIN       = 16'sh8000; // -32768
  localparam logic signed [15:0] S16_MAX       = 16'sh7FFF; // 32767
  localparam logic signed [15:0] S16_ZERO      = 16'sh0000;

  // PID mode codes that select process control
  localparam logic [1:0] PID_MODE_PROC1 = 2'h1;
  localparam logic [1:0] PID_MODE_PROC2 = 2'h2;

  // Alarm-reset hold time and its count at 250 MHz
  localparam int CLK_MHZ          = 250;
  localparam int FAULT_HOLD_NS    = 1000;
  localparam int FAULT_HOLD_CYC   = (FAULT_HOLD_NS * CLK_MHZ + 999) / 1000;

  // Selected frequency source, one-hot
  typedef enum logic [2:0] {
    SRC_PU    = 3'b001,
    SRC_HZ    = 3'b010,
    SRC_SPEED = 3'b100
  } dcb_src_t;

endpackage : dcb_pkg
`default_nettype wire

//--- logic/dcb_clamp.sv
// Signed clamp of one 16-bit command into a window.
// Assumes lo is not above hi; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module dcb_clamp
  import dcb_pkg::*;
#(
  parameter int W = WORD_W
) (
  input  wire logic signed [W-1:0] value,   // Raw command
  input  wire logic signed [W-1:0] lo,      // Lower bound
  input  wire logic signed [W-1:0] hi,      // Upper bound
  output var  logic signed [W-1:0] clamped  // Bounded command
);

  // Pick bound or value
  always_comb begin
    if (value < lo) begin
      clamped = lo;
    end else if (value > hi) begin
      clamped = hi;
    end else begin
      clamped = value;
    end
  end

endmodule : dcb_clamp
`default_nettype wire

//--- logic/dcb_hold_timer.sv
// Retriggerable hold timer: a start pulse holds active for HOLD cycles.
// Assumes start is a one-cycle pulse on the core clock.
`timescale 1ns/1ns
`default_nettype none
module dcb_hold_timer
  import dcb_pkg::*;
#(
  parameter int HOLD = FAULT_HOLD_CYC
) (
  input  wire logic clk,      // Core clock
  input  wire logic sys_rst,  // Synchronous reset, high
  input  wire logic start,    // Trigger pulse
  output var  logic active    // Held level, from a flop
);

  logic [15:0] cnt_ff;      // Cycles left
  logic [15:0] nxt_cnt;
  logic        active_ff;   // Registered level
  logic        nxt_active;

  // Load on start, count down otherwise
  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_active = active_ff;
    if (start) begin
      nxt_cnt    = 16'(HOLD - 1);
      nxt_active = 1'b1;
    end else if (cnt_ff != 16'h0000) begin
      nxt_cnt    = cnt_ff - 16'h0001;
    end else begin
      nxt_active = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff    <= 16'h0000;
      active_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

  assign active = active_ff;

  hold_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    start |=> active)
    else $error("hold timer did not start");

endmodule : dcb_hold_timer
`default_nettype wire

//--- dv/dcb_host_model.sv
// Remote host model: word writes and reads on the function-code port.
// Assumes the bank answers each read with a one-cycle valid pulse.
`timescale 1ns/1ns
`default_nettype none
module dcb_host_model
  import dcb_pkg::*;
(
  input  wire logic        clk,        // Core clock
  output var  logic        cmd_wr,     // Write strobe
  output var  logic        cmd_rd,     // Read strobe
  output var  logic [7:0]  cmd_code,   // Function code
  output var  logic [15:0] cmd_wdata,  // Write word
  input  wire logic [15:0] cmd_rdata,  // Read word
  input  wire logic        cmd_rvalid  // Read valid pulse
);
  // Idle port, data never left showing a real word
  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'hFFFF;
  end

  // One write, strobe held over exactly one taking edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    #1;
    cmd_wr    = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(posedge clk);
    #1;
    cmd_wr    = 1'b0;
    cmd_wdata = ~data;
  endtask : wr

  // One read; ok stays low when no valid pulse comes in four cycles
  task automatic rd(input logic [7:0] code, output logic [15:0] data,
                    output bit ok);
    int n;
    @(posedge clk);
    #1;
    cmd_rd   = 1'b1;
    cmd_code = code;
    @(posedge clk);
    #1;
    cmd_rd = 1'b0;
    ok     = 1'b0;
    data   = 16'h0000;
    for (n = 0; n < 4 && !ok; n++) begin
      if (cmd_rvalid === 1'b1) begin
        ok   = 1'b1;
        data = cmd_rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask : rd

  // Alarm reset through the run word: bit 15 set, then cleared
  task automatic word_reset(input logic [15:0] word);
    wr(CODE_RUN_WORD, word | 16'h8000);
    wr(CODE_RUN_WORD, word & 16'h7FFF);
  endtask : word_reset
endmodule : dcb_host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench of the command-data bank against a word model.
// Assumes the host model owns the code port; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import dcb_pkg::*;
;
  localparam int HOLD = 4;                 // Short alarm-reset hold
  logic        clk, sys_rst;               // Clock, reset
  logic        link_src_valid;             // Link source allowed
  logic        link_enable_input;          // Enable pin
  logic [1:0]  pid_mode_select;            // PID mode
  logic [15:0] freq_limit_pu;              // Upper limit
  logic        cmd_wr, cmd_rd, cmd_rvalid, fault_reset, rtc_load;
  logic [7:0]  cmd_code;                   // Function code
  logic [2:0]  freq_src;                   // Chosen source
  logic [15:0] cmd_wdata, cmd_rdata, freq_pu_applied, freq_hz_applied;
  logic [15:0] speed_applied, pid_applied, ext_pid_one, ext_pid_two;
  logic [15:0] ext_pid_three, gp_input_word, rtc_year_month;
  logic [15:0] rtc_day_hour, rtc_min_sec;
  int          error_cnt, num_checks;      // Mismatches, comparisons
  int          mdl [int];                  // Last word written per code
  logic [7:0]  rw_codes [11] = '{8'h01, 8'h05, 8'h06, 8'h0D, 8'h13,
    8'h1F, 8'h20, 8'h21, 8'h5A, 8'h5B, 8'h5C};
  int          pu_vals [5] = '{20000, 20001, -20001, 32767, -32768};

  dcb_cmd_bank #(.HOLD_CYC(HOLD)) DUT (.clk, .sys_rst, .cmd_wr, .cmd_rd,
    .cmd_code, .cmd_wdata, .link_src_valid, .link_enable_input,
    .pid_mode_select, .freq_limit_pu, .cmd_rdata, .cmd_rvalid, .freq_src,
    .freq_pu_applied, .freq_hz_applied, .speed_applied, .pid_applied,
    .ext_pid_one, .ext_pid_two, .ext_pid_three, .gp_input_word,
    .fault_reset, .rtc_load, .rtc_year_month, .rtc_day_hour, .rtc_min_sec);
  dcb_host_model host (.clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .cmd_rdata, .cmd_rvalid);

  // 250 MHz clock
  always #2 clk = ~clk;

  function automatic int get(int c);
    return mdl.exists(c) ? mdl[c] : 0;
  endfunction : get
  function automatic int s16(int x);
    return (x >= 32768) ? x - 65536 : x;
  endfunction : s16

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Write through the host and update the model
  task automatic wr(logic [7:0] c, logic [15:0] d);
    host.wr(c, d);
    if (c inside {rw_codes}) mdl[c] = d;
    if (c == CODE_CLK_CMT) mdl[c] = (d == COMMIT_GO) ? 0 : d;
  endtask : wr

  // Read and compare; a missing answer ends the run
  task automatic rdchk(logic [7:0] c);
    logic [15:0] d;
    bit          ok;
    host.rd(c, d, ok);
    if (!ok) begin
      error_cnt++;
      stop_test();
    end else begin
      chk("cmd_rdata", 16'(get(c)), d);
    end
  endtask : rdchk

  // Count cycles with fault_reset (sel 0) or rtc_load (sel 1) high
  task automatic count_hi(bit sel, int n, output int c);
    c = 0;
    repeat (n) begin
      c += ((sel ? rtc_load : fault_reset) === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask : count_hi

  // Applied outputs against the model
  task automatic chk_applied();
    int l, p, e;
    l = s16(int'(freq_limit_pu));
    l = (l < 0 || l >= 20000) ? 20000 : l;
    p = s16(get(1));
    e = (p > l) ? l : (p < -l) ? -l : p;
    chk("freq_pu_applied", 16'(e), freq_pu_applied);
    e = (get(1) != 0) ? 1 : (get(5) != 0) ? 2 : 4;
    chk("freq_src", 16'(e), {13'h0000, freq_src});
    chk("freq_hz_applied", 16'(get(5)), freq_hz_applied);
    chk("speed_applied", 16'(get(19)), speed_applied);
    chk("ext_pid_one", 16'(get(31)), ext_pid_one);
    chk("ext_pid_two", 16'(get(32)), ext_pid_two);
    chk("ext_pid_three", 16'(get(33)), ext_pid_three);
    chk("gp_input_word", 16'(get(6)), gp_input_word);
    p = s16(get(13));
    if (pid_mode_select inside {2'h1, 2'h2} && p < 0) p = 0;
    chk("pid_applied", 16'(p), pid_applied);
  endtask : chk_applied

  // Main sequence
  initial begin
    int c;
    clk = 1'b0;
    sys_rst = 1'b1;
    link_src_valid = 1'b0;
    link_enable_input = 1'b0;
    pid_mode_select = 2'h0;
    freq_limit_pu = 16'h4E20;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'hBE84));
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // Reset contents, clear pulse and unmapped code read zero
    foreach (rw_codes[k]) rdchk(rw_codes[k]);
    rdchk(CODE_FAULT_CLR);
    rdchk(8'h02);
    chk_applied();
    // Random words with zero sources mixed in
    for (int i = 0; i < 9; i++) begin
      foreach (rw_codes[k]) wr(rw_codes[k], 16'($urandom));
      if (i % 3 == 0) wr(CODE_FREQ_PU, 16'h0000);
      if (i % 2 == 0) wr(CODE_FREQ_HZ, 16'h0000);
      wr(8'h02, 16'($urandom));
      pid_mode_select = 2'($urandom);
      freq_limit_pu = 16'($urandom);
      repeat (3) @(posedge clk);
      #1;
      chk_applied();
      foreach (rw_codes[k]) rdchk(rw_codes[k]);
    end
    // Per-unit boundaries against full scale and a low limit
    foreach (pu_vals[k]) begin
      freq_limit_pu = (k < 3) ? 16'h4E20 : 16'h0064;
      wr(CODE_FREQ_PU, 16'(pu_vals[k]));
      repeat (3) @(posedge clk);
      #1;
      chk_applied();
      rdchk(CODE_FREQ_PU);
    end
    // Commit: value two does nothing, one loads and self-clears
    wr(CODE_CLK_CMT, 16'h0002);
    count_hi(1, 5, c);
    chk("rtc_load count", 16'h0000, 16'(c));
    rdchk(CODE_CLK_CMT);
    wr(CODE_CLK_CMT, COMMIT_GO);
    count_hi(1, 5, c);
    chk("rtc_load count", 16'h0001, 16'(c));
    chk("rtc_year_month", 16'(get(90)), rtc_year_month);
    chk("rtc_day_hour", 16'(get(91)), rtc_day_hour);
    chk("rtc_min_sec", 16'(get(92)), rtc_min_sec);
    rdchk(CODE_CLK_CMT);
    // Clear pulse acts with the link side invalid
    wr(CODE_FAULT_CLR, 16'h0001);
    count_hi(0, HOLD + 4, c);
    chk("fault_reset hold", 16'(HOLD), 16'(c));
    rdchk(CODE_FAULT_CLR);
    // Run-word reset refused, then taken once the link is valid
    host.word_reset(16'h0001);
    mdl[6] = 1;
    count_hi(0, HOLD + 4, c);
    chk("word reset refused", 16'h0000, 16'(c));
    link_src_valid = 1'b1;
    link_enable_input = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    host.word_reset(16'h0001);
    count_hi(0, HOLD + 4, c);
    chk("word reset hold", 16'(HOLD), 16'(c));
    chk("gp_input_word", 16'h0001, gp_input_word);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
